// >>> src/laser_pwm_command_conditioner.sv
// Conditions the pulse-width command that gates the RF drive of the laser.
// Assumes pins arrive asynchronously to clk; rst_n is the power-on reset.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Command high means beam on, low means off; drive follows the level.
// - Above 37.5 % duty, pulses are truncated once the credit is spent, so duty settles at 37.5 %.
// - While truncation is active, the ignition-failure fault output is set.
// - Off-time beyond 200 us inserts an internal tickle pulse.
// - Tickle lasts about 4 us; a command during it merges into one drive.
// - Tickle depends on measured off-time and window on-time, never on command frequency.
// - Remote hold asserted keeps lasing disabled whatever the command does.
// - Hold release lights ready at once, then five seconds before lasing.
// - Lasing allowed only while the safety loop input is asserted.
// - Tickle only if command on-time in the 200 us window is below preset.
// - Missing permit or loop, active hold, or the fault input stops emission.
module laser_pwm_command_conditioner
    import laser_pwm_pkg::*;
#(
    parameter int WINDOW_CYCLES = WINDOW_CYC,
    parameter int ENABLE_CYCLES = ENABLE_DELAY_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pwm_cmd,
    input wire logic hold_req,
    input wire logic loop_closed,
    input wire logic permit_req,
    input wire logic fault_in,
    output var logic rf_drive,
    output var logic ready,
    output var logic lasing_enabled,
    output var logic ignition_fault
);

    localparam int CD_W = $clog2(ENABLE_CYCLES + 1);
    localparam int WIN_W = $clog2(WINDOW_CYCLES + 1);
    localparam int TKL_W = $clog2(TICKLE_CYC + 1);
    localparam int CR_W = $clog2(CREDIT_CAP + 1);
    localparam logic [CD_W-1:0] CD_LAST = CD_W'(ENABLE_CYCLES - 1);
    localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WINDOW_CYCLES - 1);
    localparam logic [WIN_W-1:0] PRESET = WIN_W'(TICKLE_PRESET_CYC);
    localparam logic [TKL_W-1:0] TKL_LEN = TKL_W'(TICKLE_CYC);
    localparam logic [CR_W-1:0] CR_CAP = CR_W'(CREDIT_CAP);
    localparam logic [CR_W-1:0] CR_COST = CR_W'(ON_COST);
    localparam logic [CR_W-1:0] CR_GAIN = CR_W'(OFF_GAIN);

    typedef struct packed {
        en_state_t state;
        logic [CD_W-1:0] cd_cnt;
        logic [WIN_W-1:0] off_cnt;
        logic [WIN_W-1:0] win_cnt;
        logic [WIN_W-1:0] on_acc;
        logic [TKL_W-1:0] tkl_cnt;
        logic [CR_W-1:0] credit;
        logic cmd_prev;
        logic limit;
        logic rf_drive;
        logic ready;
        logic lase_en;
        logic ign_fault;
    } state_t;

    localparam state_t ST_RESET = '{
        state: EN_OFF,
        cd_cnt: '0,
        off_cnt: '0,
        win_cnt: '0,
        on_acc: '0,
        tkl_cnt: '0,
        credit: CR_CAP,
        cmd_prev: 1'h0,
        limit: 1'h0,
        rf_drive: 1'h0,
        ready: 1'h0,
        lase_en: 1'h0,
        ign_fault: 1'h0
    };

    logic [IN_COUNT-1:0] pins;
    logic [IN_COUNT-1:0] lvl;
    state_t st_r;
    state_t st_nxt;
    logic cmd_s;
    logic loop_ok;
    logic lase_ok;
    logic tickle_on;
    logic fire;
    logic cmd_drive;
    logic trunc;

    // Every pin goes through the same synchroniser before use
    assign pins[IN_CMD] = pwm_cmd;
    assign pins[IN_HOLD] = hold_req;
    assign pins[IN_INTLK] = loop_closed;
    assign pins[IN_PERMIT] = permit_req;
    assign pins[IN_FAULT] = fault_in;

    pin_sync #(
        .WIDTH(IN_COUNT)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in(pins),
        .level_out(lvl)
    );

    // Helper terms shared by the next-state logic and the checks
    always_comb begin
        cmd_s = lvl[IN_CMD];
        // Hold and safety loop together decide ready and the countdown
        loop_ok = !lvl[IN_HOLD] && lvl[IN_INTLK];
        // Emission needs the count done, permit present and no fault
        lase_ok = (st_r.state == EN_ON) && loop_ok && lvl[IN_PERMIT]
            && !lvl[IN_FAULT];
        tickle_on = (st_r.tkl_cnt != '0);
        // Credit check makes the 3/8 ceiling hold once a pulse train drains the credit
        cmd_drive = cmd_s && (st_r.credit >= CR_COST);
        trunc = cmd_s && lase_ok && !cmd_drive;
        // Off-time alone triggers, qualified by window on-time
        fire = (st_r.off_cnt == WIN_LAST) && (st_r.on_acc < PRESET)
            && !tickle_on;
    end

    // Next state of the whole block
    always_comb begin
        st_nxt = st_r;
        st_nxt.cmd_prev = cmd_s;

        // Enable sequence; any loss of hold or loop restarts it
        case (st_r.state)
            EN_OFF: begin
                st_nxt.cd_cnt = '0;
                if (loop_ok) begin
                    st_nxt.state = EN_COUNT;
                end
            end
            EN_COUNT: begin
                if (!loop_ok) begin
                    st_nxt.state = EN_OFF;
                    st_nxt.cd_cnt = '0;
                end else if (st_r.cd_cnt == CD_LAST) begin
                    st_nxt.state = EN_ON;
                end else begin
                    st_nxt.cd_cnt = st_r.cd_cnt + 1'h1;
                end
            end
            EN_ON: begin
                if (!loop_ok) begin
                    st_nxt.state = EN_OFF;
                end
            end
            default: begin
                st_nxt.state = EN_OFF;
            end
        endcase

        // Off-time since the last command cycle, saturating at the window
        if (cmd_s || fire) begin
            st_nxt.off_cnt = '0;
        end else if (st_r.off_cnt != WIN_LAST) begin
            st_nxt.off_cnt = st_r.off_cnt + 1'h1;
        end

        // Free-running window with command on-time; tickle not counted
        if (st_r.win_cnt == WIN_LAST) begin
            st_nxt.win_cnt = '0;
            st_nxt.on_acc = '0;
        end else begin
            st_nxt.win_cnt = st_r.win_cnt + 1'h1;
            if (cmd_drive && lase_ok && st_r.on_acc != WIN_LAST) begin
                st_nxt.on_acc = st_r.on_acc + 1'h1;
            end
        end

        // Tickle runs to its full length even if a command arrives
        if (fire) begin
            st_nxt.tkl_cnt = TKL_LEN;
        end else if (tickle_on) begin
            st_nxt.tkl_cnt = st_r.tkl_cnt - 1'h1;
        end

        // Credit bucket: spend while driving, earn on every other cycle.
        // Truncated cycles earn too, so the ceiling settles at 3/8, not below
        if (cmd_drive && lase_ok) begin
            st_nxt.credit = st_r.credit - CR_COST;
        end else if (st_r.credit > CR_CAP - CR_GAIN) begin
            st_nxt.credit = CR_CAP;
        end else begin
            st_nxt.credit = st_r.credit + CR_GAIN;
        end

        // Limit flag holds for the pulse; set wins over a new rising edge
        if (trunc) begin
            st_nxt.limit = 1'h1;
        end else if (cmd_s && !st_r.cmd_prev) begin
            st_nxt.limit = 1'h0;
        end

        // Registered outputs; tickle ORs into the command drive
        st_nxt.rf_drive = lase_ok && (cmd_drive || tickle_on);
        st_nxt.ready = loop_ok;
        st_nxt.lase_en = lase_ok;
        st_nxt.ign_fault = st_nxt.limit;
    end

    // Single state register for the block
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rf_drive = st_r.rf_drive;
    assign ready = st_r.ready;
    assign lasing_enabled = st_r.lase_en;
    assign ignition_fault = st_r.ign_fault;

    // Checks on the design's own behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_hold_blocks: assert property (
        lvl[IN_HOLD] |=> !rf_drive && !lasing_enabled)
        else $error("drive while remote hold asserted");

    chk_loop_blocks: assert property (
        !lvl[IN_INTLK] |=> !rf_drive)
        else $error("drive while safety loop open");

    chk_permit_fault: assert property (
        (!lvl[IN_PERMIT] || lvl[IN_FAULT]) |=> !rf_drive)
        else $error("drive without permit or with fault");

    chk_ready_prompt: assert property (
        $rose(loop_ok) |=> ready ##0 !lasing_enabled [*8])
        else $error("ready late or lasing without countdown");

    chk_count_restart: assert property (
        (st_r.state == EN_COUNT && !loop_ok) |=>
            st_r.state == EN_OFF && st_r.cd_cnt == '0)
        else $error("countdown not restarted");

    chk_cmd_follows: assert property (
        (cmd_drive && lase_ok) |=> rf_drive)
        else $error("command high did not drive");

    chk_trunc_fault: assert property (
        trunc && !tickle_on |=> !rf_drive && ignition_fault)
        else $error("truncation missing or fault not flagged");

    chk_tickle_fire: assert property (
        fire |=> st_r.tkl_cnt == TKL_LEN ##1 (rf_drive || !$past(lase_ok)))
        else $error("tickle not inserted after long off-time");

    chk_tickle_len: assert property (
        (st_r.tkl_cnt <= TKL_LEN) and ($fell(tickle_on) |->
            $past(st_r.tkl_cnt) == TKL_W'(1)))
        else $error("tickle length out of range");

    chk_credit_cap: assert property (
        st_r.credit <= CR_CAP)
        else $error("duty credit above its cap");

endmodule
`default_nettype wire

// >>> src/laser_pwm_pkg.sv
// Shared constants and types for the laser pulse-width command conditioner.
// Assumes a single 25 MHz system clock; all times are converted here.
package laser_pwm_pkg;

    // System clock
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

    // Tickle measurement window, 200 us
    localparam int WINDOW_US = 200;
    localparam int WINDOW_CYC = WINDOW_US * (CLK_HZ / 1_000_000);

    // Tickle pulse length, inside the 2 to 6 us band; least time rounds up
    localparam int TICKLE_NS = 4000;
    localparam int TICKLE_CYC = (TICKLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Preset tickle value: command on-time per window that makes tickle moot
    localparam int TICKLE_PRESET_NS = 4000;
    localparam int TICKLE_PRESET_CYC =
        (TICKLE_PRESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Longest legal command pulse, 600 us
    localparam int MAX_PULSE_US = 600;
    localparam int MAX_PULSE_CYC = MAX_PULSE_US * (CLK_HZ / 1_000_000);

    // Duty ceiling 37.5 % = 3/8: an on cycle costs 5 credits, off earns 3
    localparam int DUTY_NUM = 3;
    localparam int DUTY_DEN = 8;
    localparam int ON_COST = DUTY_DEN - DUTY_NUM;
    localparam int OFF_GAIN = DUTY_NUM;
    localparam int CREDIT_CAP = ON_COST * MAX_PULSE_CYC;

    // Enable countdown after hold release, five seconds
    localparam int ENABLE_DELAY_MS = 5000;
    localparam int ENABLE_DELAY_CYC = ENABLE_DELAY_MS * (CLK_HZ / 1000);

    // Bit positions of the synchronised input vector
    localparam int IN_CMD = 0;
    localparam int IN_HOLD = 1;
    localparam int IN_INTLK = 2;
    localparam int IN_PERMIT = 3;
    localparam int IN_FAULT = 4;
    localparam int IN_COUNT = 5;

    // Emission enable sequence
    typedef enum logic [1:0] {
        EN_OFF,
        EN_COUNT,
        EN_ON
    } en_state_t;

endpackage

// >>> src/pin_sync.sv
// Three-flop input synchroniser with agreement filter, one lane per bit.
// Assumes asynchronous pin levels; output moves only when stages 2 and 3 agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin_in,
    output var logic [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;

    // One identical lane per input; stage 1 feeds stage 2 only
    for (genvar i = 0; i < WIDTH; i++) begin : g_lane
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meta_r[i] <= 1'h0;
                stage2_r[i] <= 1'h0;
                stage3_r[i] <= 1'h0;
                level_out[i] <= 1'h0;
            end else begin
                meta_r[i] <= pin_in[i];
                stage2_r[i] <= meta_r[i];
                stage3_r[i] <= stage2_r[i];
                // A glitch seen by one stage only never reaches the counters
                if (stage2_r[i] == stage3_r[i]) begin
                    level_out[i] <= stage3_r[i];
                end
            end
        end
    end

endmodule
`default_nettype wire

// >>> tb/pwm_ctrl_model.sv
// Controller model: drives pulse trains on the command pin.
// Assumes go is a one-cycle request taken while busy is low.
`timescale 1ns/1ps
`default_nettype none
module pwm_ctrl_model
    import laser_pwm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [15:0] hi_cyc,
    input wire logic [15:0] lo_cyc,
    input wire logic [7:0] reps,
    output var logic pwm_cmd,
    output var logic busy
);
    // Shortest period at the fastest allowed repetition rate
    localparam int MIN_PERIOD = 125;
    int hi_c;
    int lo_c;
    int cnt_r;
    int left_r;

    // Clip requests to what a well-behaved controller may send
    assign hi_c = (int'(hi_cyc) > MAX_PULSE_CYC) ? MAX_PULSE_CYC
                                                 : int'(hi_cyc);
    assign lo_c = (hi_c + int'(lo_cyc) < MIN_PERIOD) ? MIN_PERIOD - hi_c
                                                     : int'(lo_cyc);

    // High then low phase per repetition; pin rests low when idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_cmd <= 1'b0;
            busy <= 1'b0;
            cnt_r <= 0;
            left_r <= 0;
        end else if (!busy) begin
            if (go) begin
                pwm_cmd <= 1'b1;
                busy <= 1'b1;
                cnt_r <= hi_c;
                left_r <= int'(reps);
            end
        end else if (cnt_r > 1) begin
            cnt_r <= cnt_r - 1;
        end else if (pwm_cmd) begin
            pwm_cmd <= 1'b0;
            cnt_r <= lo_c;
        end else if (left_r > 1) begin
            pwm_cmd <= 1'b1;
            cnt_r <= hi_c;
            left_r <= left_r - 1;
        end else begin
            busy <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the laser pulse-width command conditioner.
// Assumes the controller model drives the command pin; bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import laser_pwm_pkg::*;
    // Short window and countdown keep the run brief
    localparam int WIN = 300;
    localparam int ENA = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hold_req = 1'b1;
    logic loop_closed = 1'b1;
    logic permit_req = 1'b1;
    logic fault_in = 1'b0;
    logic go = 1'b0;
    logic [15:0] hi_cyc = 16'h0;
    logic [15:0] lo_cyc = 16'h0;
    logic [7:0] reps = 8'h0;
    logic pwm_cmd;
    logic busy;
    logic rf_drive;
    logic ready;
    logic lasing_enabled;
    logic ignition_fault;
    int num_errors = 0;
    int num_checks = 0;
    int on;
    int t_rdy;
    int t_en;

    // 25 MHz clock
    always #20 clk = ~clk;

    pwm_ctrl_model i_ctrl (.clk(clk), .rst_n(rst_n), .go(go),
        .hi_cyc(hi_cyc), .lo_cyc(lo_cyc), .reps(reps), .pwm_cmd(pwm_cmd),
        .busy(busy));

    laser_pwm_command_conditioner #(.WINDOW_CYCLES(WIN), .ENABLE_CYCLES(ENA))
    i_dut (.clk(clk), .rst_n(rst_n), .pwm_cmd(pwm_cmd), .hold_req(hold_req),
        .loop_closed(loop_closed), .permit_req(permit_req),
        .fault_in(fault_in), .rf_drive(rf_drive), .ready(ready),
        .lasing_enabled(lasing_enabled), .ignition_fault(ignition_fault));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic timeout();
        num_errors++;
        $display("unexpected at %0t: wait ran out", $time);
        wrap_up();
    endtask

    // Run a pulse train; count driven cycles including the latency tail
    task automatic train(input int h, input int l, input int r);
        int i;
        @(posedge clk);
        hi_cyc <= 16'(h);
        lo_cyc <= 16'(l);
        reps <= 8'(r);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        on = 0;
        for (i = 0; i < 60000; i++) begin
            @(negedge clk);
            if (rf_drive === 1'b1)
                on++;
            if (busy === 1'b0)
                break;
        end
        if (i == 60000)
            timeout();
        repeat (8) begin
            @(negedge clk);
            if (rf_drive === 1'b1)
                on++;
        end
    endtask

    // Times of ready and enable rise after a release on the last edge
    task automatic enable_wait();
        int i;
        t_rdy = -1;
        t_en = -1;
        for (i = 1; i < 300; i++) begin
            @(negedge clk);
            if (t_rdy < 0 && ready === 1'b1)
                t_rdy = i;
            if (lasing_enabled === 1'b1) begin
                t_en = i;
                break;
            end
        end
        if (t_en < 0)
            timeout();
    endtask

    task automatic s_enable();
        @(posedge clk);
        hold_req <= 1'b0;
        enable_wait();
        check(t_rdy >= 0 && t_rdy <= 8, 1'b1);
        check(t_en >= ENA && t_en <= ENA + 10, 1'b1);
    endtask

    task automatic s_pulse();
        train(60, 200, 3);
        check(on, 180);
        check(ignition_fault, 1'b0);
    endtask

    // Long gap gets one tickle; a gap under the window gets none
    task automatic s_tickle();
        train(40, WIN + 150, 1);
        check(on >= 90 && on <= 190, 1'b1);
        train(40, WIN - 60, 1);
        check(on, 40);
    endtask

    // 75 percent command drains the credit, then duty settles at 3/8:
    // 20 periods of 400 cycles leave room for about 3000 driven cycles
    task automatic s_duty();
        train(300, 100, 80);
        check(ignition_fault, 1'b1);
        train(300, 100, 20);
        check(on >= 2900 && on <= 3100, 1'b1);
        check(ignition_fault, 1'b1);
    endtask

    // Each blocking input in turn must stop all drive
    task automatic s_gate();
        int k;
        for (k = 0; k < 4; k++) begin
            @(posedge clk);
            hold_req <= (k == 0);
            loop_closed <= (k != 1);
            permit_req <= (k != 2);
            fault_in <= (k == 3);
            repeat (8) @(negedge clk);
            check(lasing_enabled, 1'b0);
            check(ready, k > 1);
            train(40, 100, 2);
            check(on, 0);
            @(posedge clk);
            hold_req <= 1'b0;
            loop_closed <= 1'b1;
            permit_req <= 1'b1;
            fault_in <= 1'b0;
            enable_wait();
            check(k > 1 || t_en >= ENA, 1'b1);
        end
    endtask

    // A second hold in mid-countdown must start the count over
    task automatic s_restart();
        @(posedge clk);
        hold_req <= 1'b1;
        repeat (10) @(posedge clk);
        hold_req <= 1'b0;
        repeat (ENA / 2 + 5) @(posedge clk);
        hold_req <= 1'b1;
        repeat (10) @(posedge clk);
        hold_req <= 1'b0;
        enable_wait();
        check(t_en >= ENA && t_en <= ENA + 10, 1'b1);
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        s_enable();
        s_pulse();
        s_tickle();
        s_duty();
        s_gate();
        s_restart();
        wrap_up();
    end
endmodule
`default_nettype wire
